// ===== rtl/rcg_pkg.sv
// Constants and types shared by the run-mode clock gate bank
`default_nettype none

package rcg_pkg;

	// ****************************************************
	// Bus geometry
	// ****************************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int NUM_UNITS = 11;

	// ****************************************************
	// Register byte offsets
	// ****************************************************
	localparam logic [11:0] OFF_RUN_GATE = 12'h104;
	localparam logic [11:0] OFF_SLEEP_GATE = 12'h114;
	localparam logic [11:0] OFF_DEEP_GATE = 12'h124;
	localparam logic [11:0] OFF_RUN_CFG = 12'h060;
	localparam logic [11:0] OFF_FAULT_STAT = 12'h130;
	localparam logic [11:0] OFF_FAULT_MASK = 12'h134;

	// ****************************************************
	// Gating word layout
	// ****************************************************
	localparam int BIT_ASYNC_SERIAL = 0;
	localparam int BIT_SYNC_SERIAL = 4;
	localparam int BIT_QUAD_DECODER = 8;
	localparam int BIT_TWO_WIRE = 12;
	localparam int BIT_COUNTER_ZERO = 16;
	localparam int BIT_COMPARATOR_ZERO = 24;
	localparam int NUM_COUNTERS = 4;
	localparam int NUM_COMPARATORS = 3;
	// Writable bits of the gating words; all others read as zero
	localparam logic [31:0] GATE_IMPL_MASK = 32'h070f_1111;
	localparam logic [31:0] GATE_RESET = 32'h0000_0000;

	// ****************************************************
	// Run clock configuration word
	// ****************************************************
	localparam int BIT_AUTO_GATING_SELECT = 27;
	localparam logic [31:0] CFG_IMPL_MASK = 32'h0800_0000;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;

	// ****************************************************
	// Fault status and mask, one bit per unit index
	// ****************************************************
	localparam logic [10:0] UNIT_RESET = 11'h000;

	// ****************************************************
	// Unit indices into the eleven-wide enable vector
	// ****************************************************
	localparam int IDX_ASYNC_SERIAL = 0;
	localparam int IDX_SYNC_SERIAL = 1;
	localparam int IDX_QUAD_DECODER = 2;
	localparam int IDX_TWO_WIRE = 3;
	localparam int IDX_COUNTER_ZERO = 4;
	localparam int IDX_COMPARATOR_ZERO = 8;

	// ****************************************************
	// AXI responses
	// ****************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Which gating pattern is in force
	typedef enum logic [1:0] {
		PAT_RUN,
		PAT_SLEEP,
		PAT_DEEP
	} rcg_pattern_t;

endpackage

`default_nettype wire

// ===== rtl/rcg_clk_gate_cell.sv
// Glitch-free latch-based clock gate for one peripheral unit
`timescale 1ns/1ps
`default_nettype none

module rcg_clk_gate_cell (
	input wire logic clk,
	input wire logic enable,
	output logic gatedClk
);

	// ****************************************************
	// Enable latch
	// ****************************************************
	logic enableLatched;

	// Transparent while clk low, so enable changes never chop a high phase
	always_latch begin
		if (!clk) begin
			enableLatched <= enable;
		end
	end

	// Gated clock
	assign gatedClk = clk & enableLatched;

endmodule

`default_nettype wire

// ===== rtl/rcg_run_gate_bank.sv
// Run-mode clock gate bank one with AXI4-Lite registers and fault check
`timescale 1ns/1ps
`default_nettype none

module rcg_run_gate_bank (
	input wire logic clk,
	input wire logic nrst,
	// AXI4-Lite write address
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Power state requests from the system controller
	input wire logic sleepReq,
	input wire logic deepSleepReq,
	// Peripheral access attempts, one bit per unit
	input wire logic [10:0] unitAccess,
	output logic [10:0] unitFault,
	// Gated clocks and registered enables per unit
	output logic [10:0] unitClk,
	output logic [10:0] unitEnable,
	// Fault interrupt
	output logic faultIrq
);

	// ****************************************************
	// Helper functions
	// ****************************************************

	// Merge write data into a word under byte strobes and a writable mask
	function automatic logic [31:0] merge_strb(
		input logic [31:0] oldVal,
		input logic [31:0] newVal,
		input logic [3:0] strb,
		input logic [31:0] implMask
	);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < rcg_pkg::STRB_W; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = newVal[i*8 +: 8];
			end
		end
		return res & implMask;
	endfunction

	// Gather the eleven unit enables out of a gating word
	function automatic logic [10:0] unit_bits(input logic [31:0] word);
		logic [10:0] u;
		u = '0;
		u[rcg_pkg::IDX_ASYNC_SERIAL] = word[rcg_pkg::BIT_ASYNC_SERIAL];
		u[rcg_pkg::IDX_SYNC_SERIAL] = word[rcg_pkg::BIT_SYNC_SERIAL];
		u[rcg_pkg::IDX_QUAD_DECODER] = word[rcg_pkg::BIT_QUAD_DECODER];
		u[rcg_pkg::IDX_TWO_WIRE] = word[rcg_pkg::BIT_TWO_WIRE];
		for (int i = 0; i < rcg_pkg::NUM_COUNTERS; i++) begin
			u[rcg_pkg::IDX_COUNTER_ZERO + i] =
				word[rcg_pkg::BIT_COUNTER_ZERO + i];
		end
		for (int i = 0; i < rcg_pkg::NUM_COMPARATORS; i++) begin
			u[rcg_pkg::IDX_COMPARATOR_ZERO + i] =
				word[rcg_pkg::BIT_COMPARATOR_ZERO + i];
		end
		return u;
	endfunction

	// ****************************************************
	// Register state
	// ****************************************************
	logic [31:0] run_clock_gate_one;
	logic [31:0] sleep_clock_gate_one;
	logic [31:0] deep_sleep_clock_gate_one;
	logic [31:0] run_clock_config_reg;
	logic [10:0] faultStatus;
	logic [10:0] faultMask;

	// ****************************************************
	// Write channel capture
	// ****************************************************
	logic awHeld;
	logic wHeld;
	logic [11:0] awAddrHeld;
	logic [31:0] wDataHeld;
	logic [3:0] wStrbHeld;
	logic awTake;
	logic wTake;
	logic doWrite;

	// One write under way at a time; address and data in either order
	assign awready = !awHeld && !bvalid;
	assign wready = !wHeld && !bvalid;
	assign awTake = awvalid && awready;
	assign wTake = wvalid && wready;
	assign doWrite = awHeld && wHeld && !bvalid;

	// Hold address and data until both have arrived
	always_ff @(posedge clk) begin
		if (!nrst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrHeld <= '0;
			wDataHeld <= '0;
			wStrbHeld <= '0;
		end else begin
			if (awTake) begin
				awHeld <= 1'b1;
				awAddrHeld <= awaddr;
			end else if (doWrite) begin
				awHeld <= 1'b0;
			end
			if (wTake) begin
				wHeld <= 1'b1;
				wDataHeld <= wdata;
				wStrbHeld <= wstrb;
			end else if (doWrite) begin
				wHeld <= 1'b0;
			end
		end
	end

	// ****************************************************
	// Write decode
	// ****************************************************
	logic wrRun;
	logic wrSleep;
	logic wrDeep;
	logic wrCfg;
	logic wrMask;
	logic wrStat;
	logic wrHit;

	assign wrRun = doWrite && awAddrHeld == rcg_pkg::OFF_RUN_GATE;
	assign wrSleep = doWrite && awAddrHeld == rcg_pkg::OFF_SLEEP_GATE;
	assign wrDeep = doWrite && awAddrHeld == rcg_pkg::OFF_DEEP_GATE;
	assign wrCfg = doWrite && awAddrHeld == rcg_pkg::OFF_RUN_CFG;
	assign wrMask = doWrite && awAddrHeld == rcg_pkg::OFF_FAULT_MASK;
	// Status is read-only; a write is accepted and has no effect
	assign wrStat = doWrite && awAddrHeld == rcg_pkg::OFF_FAULT_STAT;
	assign wrHit = wrRun || wrSleep || wrDeep || wrCfg || wrMask || wrStat;

	// Gating and config registers; reserved bits masked on write
	always_ff @(posedge clk) begin
		if (!nrst) begin
			run_clock_gate_one <= rcg_pkg::GATE_RESET;
			sleep_clock_gate_one <= rcg_pkg::GATE_RESET;
			deep_sleep_clock_gate_one <= rcg_pkg::GATE_RESET;
			run_clock_config_reg <= rcg_pkg::CFG_RESET;
		end else begin
			if (wrRun) begin
				run_clock_gate_one <= merge_strb(run_clock_gate_one,
					wDataHeld, wStrbHeld, rcg_pkg::GATE_IMPL_MASK);
			end
			if (wrSleep) begin
				sleep_clock_gate_one <= merge_strb(sleep_clock_gate_one,
					wDataHeld, wStrbHeld, rcg_pkg::GATE_IMPL_MASK);
			end
			if (wrDeep) begin
				deep_sleep_clock_gate_one <= merge_strb(
					deep_sleep_clock_gate_one, wDataHeld, wStrbHeld,
					rcg_pkg::GATE_IMPL_MASK);
			end
			if (wrCfg) begin
				run_clock_config_reg <= merge_strb(run_clock_config_reg,
					wDataHeld, wStrbHeld, rcg_pkg::CFG_IMPL_MASK);
			end
		end
	end

	// Write response: unmapped offsets answer with a slave error
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			bresp <= rcg_pkg::RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp <= wrHit ? rcg_pkg::RESP_OKAY : rcg_pkg::RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// ****************************************************
	// Read channel
	// ****************************************************
	logic arTake;
	logic rdStat;
	logic rdHit;
	logic [31:0] rdWord;
	logic [31:0] statWord;
	logic [31:0] maskWord;

	assign arready = !rvalid;
	assign arTake = arvalid && arready;
	assign statWord = {21'h0, faultStatus};
	assign maskWord = {21'h0, faultMask};
	assign rdStat = arTake && araddr == rcg_pkg::OFF_FAULT_STAT;

	// Read mux; reserved bits are zero because the stores are masked
	always_comb begin
		rdHit = 1'b1;
		case (araddr)
			rcg_pkg::OFF_RUN_GATE: rdWord = run_clock_gate_one;
			rcg_pkg::OFF_SLEEP_GATE: rdWord = sleep_clock_gate_one;
			rcg_pkg::OFF_DEEP_GATE: rdWord = deep_sleep_clock_gate_one;
			rcg_pkg::OFF_RUN_CFG: rdWord = run_clock_config_reg;
			rcg_pkg::OFF_FAULT_STAT: rdWord = statWord;
			rcg_pkg::OFF_FAULT_MASK: rdWord = maskWord;
			default: begin
				rdWord = '0;
				rdHit = 1'b0;
			end
		endcase
	end

	// Read data registered one cycle after the address is taken
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= rcg_pkg::RESP_OKAY;
		end else if (arTake) begin
			rvalid <= 1'b1;
			rdata <= rdWord;
			rresp <= rdHit ? rcg_pkg::RESP_OKAY : rcg_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ****************************************************
	// Pattern selection
	// ****************************************************
	rcg_pkg::rcg_pattern_t patSel;
	logic autoGating;
	logic [31:0] activeWord;
	logic [10:0] next_unitEnable;

	assign autoGating = run_clock_config_reg[rcg_pkg::BIT_AUTO_GATING_SELECT];

	// Low-power patterns only when auto-gating is selected
	always_comb begin
		if (autoGating && deepSleepReq) begin
			patSel = rcg_pkg::PAT_DEEP;
		end else if (autoGating && sleepReq) begin
			patSel = rcg_pkg::PAT_SLEEP;
		end else begin
			patSel = rcg_pkg::PAT_RUN;
		end
	end

	// Gating word in force for the chosen pattern
	always_comb begin
		case (patSel)
			rcg_pkg::PAT_RUN: activeWord = run_clock_gate_one;
			rcg_pkg::PAT_SLEEP: activeWord = sleep_clock_gate_one;
			rcg_pkg::PAT_DEEP: activeWord = deep_sleep_clock_gate_one;
			default: activeWord = run_clock_gate_one;
		endcase
	end

	// Bit 0, 4, 8, 12, 19:16 and 26:24 map onto unit indices
	assign next_unitEnable = unit_bits(activeWord);

	// Registered so the gate cells see a clean, glitch-free enable
	always_ff @(posedge clk) begin
		if (!nrst) begin
			unitEnable <= rcg_pkg::UNIT_RESET;
		end else begin
			unitEnable <= next_unitEnable;
		end
	end

	// ****************************************************
	// Clock gate cells
	// ****************************************************
	// One latch-based cell per unit keeps the gated clocks free of runts
	for (genvar g = 0; g < rcg_pkg::NUM_UNITS; g++) begin : gateCells
		rcg_clk_gate_cell gateCell (
			.clk(clk),
			.enable(unitEnable[g]),
			.gatedClk(unitClk[g])
		);
	end

	// ****************************************************
	// Access fault and interrupt
	// ****************************************************
	// Fault is combinational so the access can be ended in its own cycle
	assign unitFault = unitAccess & ~unitEnable;

	// Sticky status; a new fault beats the clear of a status read
	always_ff @(posedge clk) begin
		if (!nrst) begin
			faultStatus <= rcg_pkg::UNIT_RESET;
		end else if (rdStat) begin
			faultStatus <= unitFault;
		end else begin
			faultStatus <= faultStatus | unitFault;
		end
	end

	// Interrupt mask
	always_ff @(posedge clk) begin
		if (!nrst) begin
			faultMask <= rcg_pkg::UNIT_RESET;
		end else if (wrMask) begin
			faultMask <= 11'(merge_strb(maskWord, wDataHeld, wStrbHeld,
				{21'h0, {rcg_pkg::NUM_UNITS{1'b1}}}));
		end
	end

	// Level interrupt while any unmasked fault is pending
	assign faultIrq = |(faultStatus & faultMask);

endmodule

`default_nettype wire

// ===== verification/rcg_run_gate_bank_props.sv
// Assertion checker for the run-mode clock gate bank
`timescale 1ns/1ps
`default_nettype none

module rcg_run_gate_bank_props (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic sleepReq,
	input wire logic deepSleepReq,
	input wire logic [10:0] unitAccess,
	input wire logic [10:0] unitFault,
	input wire logic [10:0] unitClk,
	input wire logic [10:0] unitEnable,
	input wire logic faultIrq
);
	// ****
	// Helper logic
	// ****
	wire logic [10:0] tog;
	logic [10:0] mapW;
	logic bothIn;
	logic gateRd = 1'b0;
	logic nrstQ = 1'b0;
	// Enables a full-word run write should give
	assign mapW = {wdata[26:24], wdata[19:16], wdata[12], wdata[8],
		wdata[4], wdata[0]};
	assign bothIn = awvalid && awready && wvalid && wready;
	// Toggle per gated pulse, so pulses can be counted on the clk domain
	for (genvar i = 0; i < 11; i++) begin : g_tog
		logic t = 1'b0;
		always @(posedge unitClk[i]) begin
			t <= !t;
		end
		assign tog[i] = t;
	end
	// Remember whether the pending read data come from a gating word
	always @(posedge clk) begin
		if (arvalid && arready) begin
			gateRd <= araddr == rcg_pkg::OFF_RUN_GATE ||
				araddr == rcg_pkg::OFF_SLEEP_GATE ||
				araddr == rcg_pkg::OFF_DEEP_GATE;
		end
	end
	// Delayed reset; the release edge still sees pre-reset history
	always @(posedge clk) begin
		nrstQ <= nrst;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst || !nrstQ);

	// ****
	// Properties
	// ****
	a_fault_same_cycle: assert property (
		unitFault == (unitAccess & ~unitEnable))
		else $error("unit fault differs from access and enable");
	a_pulse_per_enable: assert property (
		(tog ^ $past(tog)) == $past(unitEnable))
		else $error("gated pulses differ from enables");
	a_reserved_zero: assert property (
		rvalid |-> (rdata & (gateRd ? ~rcg_pkg::GATE_IMPL_MASK :
			32'hf0f0_e000)) == 32'h0)
		else $error("reserved read bits not zero");
	a_reset_clears: assert property (
		$rose(nrst) |-> unitEnable == 11'h000 && !bvalid && !rvalid)
		else $error("state not cleared by reset");
	a_run_write_maps: assert property (
		bothIn && awaddr == rcg_pkg::OFF_RUN_GATE && wstrb == 4'hf &&
		!sleepReq && !deepSleepReq |-> ##3 unitEnable == $past(mapW, 3))
		else $error("run write gave wrong enables");
	a_bus_busy_refuse: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	a_read_ready: assert property (arready == !rvalid)
		else $error("read ready not inverse of read valid");
	a_write_answer: assert property (bothIn |-> ##2 bvalid)
		else $error("write response late");

	c_slverr: cover property (bvalid && bresp == rcg_pkg::RESP_SLVERR);
	c_fault: cover property (|unitFault);
	c_irq: cover property (faultIrq);
endmodule

bind rcg_run_gate_bank rcg_run_gate_bank_props u_props (.clk, .nrst,
	.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
	.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
	.rready, .sleepReq, .deepSleepReq, .unitAccess, .unitFault, .unitClk,
	.unitEnable, .faultIrq);

`default_nettype wire

// ===== verification/rcg_run_gate_bank_tb.sv
// Self-checking testbench for the run-mode clock gate bank
`timescale 1ns/1ps
`default_nettype none

module rcg_run_gate_bank_tb;
	logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic sleepReq, deepSleepReq, awready, wready, bvalid, arready, rvalid;
	logic faultIrq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [10:0] unitAccess, unitFault, unitClk, unitEnable;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	localparam logic [1:0] OK = rcg_pkg::RESP_OKAY;
	localparam logic [1:0] ER = rcg_pkg::RESP_SLVERR;
	typedef struct {logic [11:0] a; logic [31:0] w, x; logic [10:0] e;
		logic [1:0] r;} rcg_row_t;
	// Address, write, read expect, enables expect, response
	rcg_row_t rows[10] = '{'{12'h104, 32'hffffffff, 32'h070f1111, 11'h7ff, OK},
		'{12'h104, 32'h1, 32'h1, 11'h001, OK},
		'{12'h104, 32'h10, 32'h10, 11'h002, OK},
		'{12'h104, 32'h100, 32'h100, 11'h004, OK},
		'{12'h104, 32'h1000, 32'h1000, 11'h008, OK},
		'{12'h104, 32'h10000, 32'h10000, 11'h010, OK},
		'{12'h104, 32'h80000, 32'h80000, 11'h080, OK},
		'{12'h104, 32'h1000000, 32'h1000000, 11'h100, OK},
		'{12'h104, 32'hf8f0eeee, 32'h0, 11'h000, OK},
		'{12'h200, 32'hffffffff, 32'h0, 11'h000, ER}};

	rcg_run_gate_bank dut (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .sleepReq, .deepSleepReq,
		.unitAccess, .unitFault, .unitClk, .unitEnable, .faultIrq);

	// ****
	// Tasks
	// ****
	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task give_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Handshakes judged at the negedge before the deciding rising edge
	task wr(input logic [11:0] a, input logic [31:0] w, input logic [3:0] s);
		logic ah, wh, bh;
		@(posedge clk);
		awaddr <= a;
		wdata <= w;
		wstrb <= s;
		{awvalid, wvalid, bready} <= 3'b111;
		do begin
			@(negedge clk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			r = bresp;
			@(posedge clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (!bh);
		bready <= 1'b0;
	endtask
	task rd(input logic [11:0] a);
		logic ah, rh;
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do begin
			@(negedge clk);
			ah = arvalid && arready;
			rh = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ah) arvalid <= 1'b0;
		end while (!rh);
		rready <= 1'b0;
	endtask
	// One-cycle access attempt, fault seen in that cycle
	task poke(input logic [10:0] u, input logic [10:0] f);
		@(posedge clk);
		unitAccess <= u;
		@(negedge clk);
		chk("fault", unitFault, f);
		@(posedge clk);
		unitAccess <= 11'h000;
		@(negedge clk);
	endtask
	task settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	// Clock and hang guard
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			give_verdict();
		end
	end

	// ****
	// Main sequence
	// ****
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{sleepReq, deepSleepReq} = '0;
		{awaddr, araddr, wdata, wstrb, unitAccess} = '0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(12'h104);
		chk("reset", d, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w, 4'hf);
			chk("wresp", r, rows[i].r);
			rd(rows[i].a);
			chk("rdata", d, rows[i].x);
			chk("rresp", r, rows[i].r);
			chk("enable", unitEnable, rows[i].e);
		end
		$display("table done");
		wr(12'h104, 32'h070f1111, 4'hf);
		wr(12'h104, 32'h0, 4'h4);
		rd(12'h104);
		chk("strobe", d, 32'h07001111);
		wr(12'h104, 32'h0, 4'hf);
		wr(12'h134, 32'h7ff, 4'hf);
		poke(11'h001, 11'h001);
		chk("irq", faultIrq, 1'b1);
		rd(12'h130);
		chk("status", d, 32'h1);
		@(negedge clk);
		chk("irq clear", faultIrq, 1'b0);
		wr(12'h134, 32'h0, 4'hf);
		poke(11'h010, 11'h010);
		chk("irq masked", faultIrq, 1'b0);
		wr(12'h104, 32'h1, 4'hf);
		poke(11'h011, 11'h010);
		wr(12'h130, 32'h7ff, 4'hf);
		chk("stat wresp", r, OK);
		rd(12'h130);
		chk("stat keep", d, 32'h10);
		$display("fault done");
		wr(12'h114, 32'h1, 4'hf);
		rd(12'h114);
		chk("sleep word", d, 32'h1);
		wr(12'h104, 32'h10, 4'hf);
		@(posedge clk);
		sleepReq <= 1'b1;
		settle();
		chk("no auto", unitEnable, 11'h002);
		wr(12'h060, 32'h08000000, 4'hf);
		@(negedge clk);
		chk("sleep", unitEnable, 11'h001);
		wr(12'h124, 32'h100, 4'hf);
		rd(12'h124);
		chk("deep word", d, 32'h100);
		@(posedge clk);
		deepSleepReq <= 1'b1;
		settle();
		chk("deep", unitEnable, 11'h004);
		@(posedge clk);
		{sleepReq, deepSleepReq} <= 2'b00;
		settle();
		chk("run", unitEnable, 11'h002);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk("rst enable", unitEnable, 11'h000);
		rd(12'h060);
		chk("rst config", d, 32'h0);
		$display("modes done");
		give_verdict();
	end
endmodule

`default_nettype wire
